// file: rtl/srp_consts.vh
// Constants of the profile RAM segment register bank
// Summary of operation
// - The profile two segment word at address 0x09 is applied only when select low is 0 and select high is 1, and its ten-bit beginning address spans the first two bytes.
// - Each segment word holds a ten-bit final address whose top two bits sit in bits 9:8 and whose low eight bits fill bits 23:16.
// - The RAM enable bit of control word one gates only the waveform RAM, never the segment words.
// - With the linear sweep enable bit 21 set, the segment words are replaced by the sweep map and are not reachable here.
// - Control word two at address 0x01 holds multiplier, range and two-bit charge pump current in its low byte and resets to zero.
`ifndef SRP_CONSTS_VH
`define SRP_CONSTS_VH

// ************************************************************
// Serial addresses
// ************************************************************
`define SRP_ADDR_CTRL_ONE     5'h00
`define SRP_ADDR_CTRL_TWO     5'h01
`define SRP_ADDR_SEG_ONE      5'h08
`define SRP_ADDR_SEG_TWO      5'h09
`define SRP_ADDR_SEG_THREE    5'h0A
`define SRP_ADDR_RAM          5'h0B

// ************************************************************
// Register lengths in serial bits
// ************************************************************
`define SRP_LEN_CTRL_ONE      6'd32
`define SRP_LEN_CTRL_TWO      6'd16
`define SRP_LEN_SEG           6'd40
`define SRP_LEN_RAM           6'd32
`define SRP_LEN_NONE          6'd0

// ************************************************************
// Field positions
// ************************************************************
`define SRP_INSTR_READ_BIT    7
`define SRP_CTRL_RAM_EN_BIT   31
`define SRP_CTRL_SWEEP_BIT    21
`define SRP_SEG_MODE_MSB      7
`define SRP_SEG_MODE_LSB      5
`define SRP_SEG_NODWELL_BIT   4
`define SRP_SEG_BEGIN_HI_MSB  3
`define SRP_SEG_BEGIN_LO_MSB  15
`define SRP_SEG_BEGIN_LO_LSB  10
`define SRP_SEG_FINAL_HI_MSB  9
`define SRP_SEG_FINAL_HI_LSB  8
`define SRP_SEG_FINAL_LO_MSB  23
`define SRP_SEG_FINAL_LO_LSB  16
`define SRP_SEG_RATE_HI_MSB   31
`define SRP_SEG_RATE_HI_LSB   24
`define SRP_SEG_RATE_LO_MSB   39
`define SRP_SEG_RATE_LO_LSB   32
`define SRP_CTRL2_MULT_MSB    7
`define SRP_CTRL2_MULT_LSB    3
`define SRP_CTRL2_VCO_BIT     2
`define SRP_CTRL2_PUMP_MSB    1

// ************************************************************
// Reset values
// ************************************************************
`define SRP_RST_CTRL_ONE      32'h0000_0000
`define SRP_RST_CTRL_TWO      16'h0000
`define SRP_RST_SEG           40'h00_0000_0000
`define SRP_RST_SIG           32'h0000_0000

`endif

// file: rtl/srp_profile_regs.v
// Serial register bank for control words, profile segment words and waveform RAM
`timescale 1ns/1ps
`default_nettype none
`include "srp_consts.vh"
module srp_profile_regs #(
    parameter RAM_AW = 10,
    parameter RAM_DW = 32
) (
    input  wire              CLK,
    input  wire              RST,
    input  wire              CS_N,
    input  wire              SCLK,
    input  wire              SDIO_IN,
    output wire              SDIO_OUT,
    output wire              SDIO_OE_N,
    input  wire              PROFILE_SELECT_LOW,
    input  wire              PROFILE_SELECT_HIGH,
    output wire [31:0]       CTRL_ONE,
    output wire [15:0]       CTRL_TWO,
    output wire [4:0]        REF_MULT,
    output wire              VCO_RANGE,
    output wire [1:0]        PUMP_CURRENT,
    output wire              SWEEP_MAP,
    output reg               SEG_VALID,
    output reg  [2:0]        SEG_MODE,
    output reg               SEG_NO_DWELL,
    output reg  [RAM_AW-1:0] SEG_BEGIN,
    output reg  [RAM_AW-1:0] SEG_FINAL,
    output reg  [15:0]       SEG_RATE,
    output reg  [RAM_AW-1:0] RAM_ADDR,
    output wire [RAM_DW-1:0] RAM_DATA
);
    // ************************************************************
    // States and storage
    // ************************************************************
    localparam [2:0] ST_INSTR = 3'b001;
    localparam [2:0] ST_DATA  = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    reg  [2:0]        state;
    reg               sclk_d;
    reg  [39:0]       shift;
    reg  [39:0]       tx;
    reg  [5:0]        bit_cnt;
    reg               rd_op;
    reg  [4:0]        addr;
    reg  [31:0]       ctrl_one;
    reg  [15:0]       ctrl_two;
    reg  [39:0]       seg [0:2];
    reg  [31:0]       signature;
    reg  [RAM_AW-1:0] wr_ptr;
    reg  [15:0]       rate_cnt;
    reg               ram_we;
    reg  [RAM_DW-1:0] ram_wdata;
    reg  [RAM_AW-1:0] ram_waddr;
    reg  [RAM_AW-1:0] play_begin;

    wire        sclk_rise = SCLK & ~sclk_d;
    wire [39:0] shift_in  = {shift[38:0], SDIO_IN};
    wire        ram_en    = ctrl_one[`SRP_CTRL_RAM_EN_BIT];
    wire        sweep     = ctrl_one[`SRP_CTRL_SWEEP_BIT];
    wire [1:0]  psel      = {PROFILE_SELECT_HIGH, PROFILE_SELECT_LOW};

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    function [5:0] reg_len;
        input [4:0] a;
        input       sw;
        begin
            case (a)
                `SRP_ADDR_CTRL_ONE: reg_len = `SRP_LEN_CTRL_ONE;
                `SRP_ADDR_CTRL_TWO: reg_len = `SRP_LEN_CTRL_TWO;
                `SRP_ADDR_SEG_ONE,
                `SRP_ADDR_SEG_TWO,
                `SRP_ADDR_SEG_THREE: reg_len = sw ? `SRP_LEN_NONE : `SRP_LEN_SEG;
                `SRP_ADDR_RAM:      reg_len = `SRP_LEN_RAM;
                default:            reg_len = `SRP_LEN_NONE;
            endcase
        end
    endfunction

    function [RAM_AW-1:0] seg_begin;
        input [39:0] w;
        begin
            seg_begin = {w[`SRP_SEG_BEGIN_HI_MSB:0],
                         w[`SRP_SEG_BEGIN_LO_MSB:`SRP_SEG_BEGIN_LO_LSB]};
        end
    endfunction

    function [RAM_AW-1:0] seg_final;
        input [39:0] w;
        begin
            seg_final = {w[`SRP_SEG_FINAL_HI_MSB:`SRP_SEG_FINAL_HI_LSB],
                         w[`SRP_SEG_FINAL_LO_MSB:`SRP_SEG_FINAL_LO_LSB]};
        end
    endfunction

    wire [5:0] cur_len = reg_len(addr, sweep);

    // ************************************************************
    // Read data for an instruction, left aligned to the shift width
    // ************************************************************
    reg [39:0] rd_word;
    always @* begin
        rd_word = 40'h00_0000_0000;
        case (shift_in[4:0])
            `SRP_ADDR_CTRL_ONE:  rd_word = {ctrl_one, 8'h00};
            `SRP_ADDR_CTRL_TWO:  rd_word = {ctrl_two, 24'h00_0000};
            `SRP_ADDR_SEG_ONE:   rd_word = sweep ? 40'h00_0000_0000 : seg[0];
            `SRP_ADDR_SEG_TWO:   rd_word = sweep ? 40'h00_0000_0000 : seg[1];
            `SRP_ADDR_SEG_THREE: rd_word = sweep ? 40'h00_0000_0000 : seg[2];
            `SRP_ADDR_RAM:       rd_word = {signature, 8'h00};
            default:             rd_word = 40'h00_0000_0000;
        endcase
    end

    // ************************************************************
    // Serial port
    // ************************************************************
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state     <= ST_INSTR;
            sclk_d    <= 1'b0;
            shift     <= 40'h00_0000_0000;
            tx        <= 40'h00_0000_0000;
            bit_cnt   <= 6'd0;
            rd_op     <= 1'b0;
            addr      <= 5'h00;
            ctrl_one  <= `SRP_RST_CTRL_ONE;
            ctrl_two  <= `SRP_RST_CTRL_TWO;
            seg[0]    <= `SRP_RST_SEG;
            seg[1]    <= `SRP_RST_SEG;
            seg[2]    <= `SRP_RST_SEG;
            signature <= `SRP_RST_SIG;
            wr_ptr    <= {RAM_AW{1'b0}};
            ram_we    <= 1'b0;
            ram_wdata <= {RAM_DW{1'b0}};
            ram_waddr <= {RAM_AW{1'b0}};
        end else begin
            sclk_d <= SCLK;
            ram_we <= 1'b0;
            if (CS_N) begin
                state   <= ST_INSTR;
                bit_cnt <= 6'd0;
                rd_op   <= 1'b0;
            end else if (sclk_rise) begin
                shift <= shift_in;
                tx    <= {tx[38:0], 1'b0};
                case (state)
                    ST_INSTR: begin
                        if (bit_cnt == 6'd7) begin
                            rd_op   <= shift_in[`SRP_INSTR_READ_BIT];
                            addr    <= shift_in[4:0];
                            tx      <= rd_word;
                            bit_cnt <= 6'd0;
                            state   <= ST_DATA;
                            // RAM transfers start at the active segment's beginning
                            wr_ptr  <= SEG_BEGIN;
                        end else begin
                            bit_cnt <= bit_cnt + 6'd1;
                        end
                    end
                    ST_DATA: begin
                        if (cur_len == `SRP_LEN_NONE) begin
                            state <= ST_DONE;
                        end else if (bit_cnt == cur_len - 6'd1) begin
                            bit_cnt <= 6'd0;
                            state   <= (addr == `SRP_ADDR_RAM) ? ST_DATA : ST_DONE;
                            if (addr == `SRP_ADDR_RAM) begin
                                tx <= {signature, 8'h00};
                            end
                            if (!rd_op) begin
                                case (addr)
                                    `SRP_ADDR_CTRL_ONE:  ctrl_one <= shift_in[31:0];
                                    `SRP_ADDR_CTRL_TWO:  ctrl_two <= shift_in[15:0];
                                    `SRP_ADDR_SEG_ONE:   seg[0]   <= shift_in;
                                    `SRP_ADDR_SEG_TWO:   seg[1]   <= shift_in;
                                    `SRP_ADDR_SEG_THREE: seg[2]   <= shift_in;
                                    `SRP_ADDR_RAM: begin
                                        if (ram_en) begin
                                            ram_we    <= 1'b1;
                                            ram_waddr <= wr_ptr;
                                            ram_wdata <= shift_in[31:0];
                                            wr_ptr    <= wr_ptr + {{(RAM_AW-1){1'b0}}, 1'b1};
                                            signature <= {signature[30:0], signature[31]}
                                                         ^ shift_in[31:0];
                                        end
                                    end
                                    default: ;
                                endcase
                            end
                        end else begin
                            bit_cnt <= bit_cnt + 6'd1;
                        end
                    end
                    ST_DONE: ;
                    default: state <= ST_INSTR;
                endcase
            end
        end
    end

    assign SDIO_OUT  = tx[39];
    assign SDIO_OE_N = ~(~CS_N && rd_op && state == ST_DATA);

    // ************************************************************
    // Active profile segment, chosen by the select pins
    // ************************************************************
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            SEG_VALID    <= 1'b0;
            SEG_MODE     <= 3'd0;
            SEG_NO_DWELL <= 1'b0;
            SEG_BEGIN    <= {RAM_AW{1'b0}};
            SEG_FINAL    <= {RAM_AW{1'b0}};
            SEG_RATE     <= 16'h0000;
        end else begin
            // Profile zero lives outside this bank, so select 00 shows no segment
            SEG_VALID <= (psel != 2'b00) && !sweep;
            if (psel != 2'b00) begin
                SEG_MODE     <= seg[psel-2'd1][`SRP_SEG_MODE_MSB:`SRP_SEG_MODE_LSB];
                SEG_NO_DWELL <= seg[psel-2'd1][`SRP_SEG_NODWELL_BIT];
                SEG_BEGIN    <= seg_begin(seg[psel-2'd1]);
                SEG_FINAL    <= seg_final(seg[psel-2'd1]);
                SEG_RATE     <= {seg[psel-2'd1][`SRP_SEG_RATE_HI_MSB:`SRP_SEG_RATE_HI_LSB],
                                 seg[psel-2'd1][`SRP_SEG_RATE_LO_MSB:`SRP_SEG_RATE_LO_LSB]};
            end else begin
                SEG_MODE     <= 3'd0;
                SEG_NO_DWELL <= 1'b0;
                SEG_BEGIN    <= {RAM_AW{1'b0}};
                SEG_FINAL    <= {RAM_AW{1'b0}};
                SEG_RATE     <= 16'h0000;
            end
        end
    end

    // ************************************************************
    // Playback address stepping at the segment ramp rate
    // ************************************************************
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            RAM_ADDR   <= {RAM_AW{1'b0}};
            rate_cnt   <= 16'h0000;
            play_begin <= {RAM_AW{1'b0}};
        end else if (!ram_en || !SEG_VALID || play_begin != SEG_BEGIN) begin
            // Segment outputs settle a cycle after a select change, so a new begin restarts
            RAM_ADDR   <= SEG_BEGIN;
            rate_cnt   <= 16'h0000;
            play_begin <= SEG_BEGIN;
        end else if (rate_cnt >= SEG_RATE) begin
            rate_cnt <= 16'h0000;
            // Simple wrap in every mode; mode decoding belongs to the sweep engine
            RAM_ADDR <= (RAM_ADDR == SEG_FINAL) ? SEG_BEGIN
                        : RAM_ADDR + {{(RAM_AW-1){1'b0}}, 1'b1};
        end else begin
            rate_cnt <= rate_cnt + 16'h0001;
        end
    end

    srp_wave_ram #(
        .DEPTH_LOG2 (RAM_AW),
        .WIDTH      (RAM_DW)
    ) u_ram (
        .clk     (CLK),
        .wr_en   (ram_we),
        .wr_addr (ram_waddr),
        .wr_data (ram_wdata),
        .rd_addr (RAM_ADDR),
        .rd_data (RAM_DATA)
    );

    assign CTRL_ONE     = ctrl_one;
    assign CTRL_TWO     = ctrl_two;
    assign REF_MULT     = ctrl_two[`SRP_CTRL2_MULT_MSB:`SRP_CTRL2_MULT_LSB];
    assign VCO_RANGE    = ctrl_two[`SRP_CTRL2_VCO_BIT];
    assign PUMP_CURRENT = ctrl_two[`SRP_CTRL2_PUMP_MSB:0];
    assign SWEEP_MAP    = sweep;
endmodule // srp_profile_regs
`default_nettype wire

// file: rtl/srp_wave_ram.v
// Waveform RAM, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module srp_wave_ram #(
    parameter DEPTH_LOG2 = 10,
    parameter WIDTH      = 32
) (
    input  wire                  clk,
    input  wire                  wr_en,
    input  wire [DEPTH_LOG2-1:0] wr_addr,
    input  wire [WIDTH-1:0]      wr_data,
    input  wire [DEPTH_LOG2-1:0] rd_addr,
    output reg  [WIDTH-1:0]      rd_data
);
    reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

    // No reset on the array; contents are undefined until written
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // srp_wave_ram
`default_nettype wire

// file: tb/srp_checker.sv
// Port assertions for the profile register bank
`timescale 1ns/1ps
`default_nettype none
module srp_checker #(
    parameter RAM_AW = 10
) (
    input wire logic              CLK,
    input wire logic              RST,
    input wire logic              CS_N,
    input wire logic              SDIO_OE_N,
    input wire logic              PROFILE_SELECT_LOW,
    input wire logic              PROFILE_SELECT_HIGH,
    input wire logic [31:0]       CTRL_ONE,
    input wire logic [15:0]       CTRL_TWO,
    input wire logic [4:0]        REF_MULT,
    input wire logic              VCO_RANGE,
    input wire logic [1:0]        PUMP_CURRENT,
    input wire logic              SWEEP_MAP,
    input wire logic              SEG_VALID,
    input wire logic [2:0]        SEG_MODE,
    input wire logic              SEG_NO_DWELL,
    input wire logic [RAM_AW-1:0] SEG_BEGIN,
    input wire logic [RAM_AW-1:0] SEG_FINAL,
    input wire logic [15:0]       SEG_RATE
);
    wire logic [1:0] sel = {PROFILE_SELECT_HIGH, PROFILE_SELECT_LOW};
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Three idle cycles let a select change settle into the segment outputs
    sequence s_quiet;
        (CS_N && $stable(sel)) [*3];
    endsequence
    a_oe_needs_select: assert property (CS_N |-> SDIO_OE_N)
        else $error("drive enable active without chip select");
    a_seg_valid_gate: assert property ($past(!RST) |->
        SEG_VALID == $past(sel != 2'b00 && !CTRL_ONE[21])) else $error("segment valid wrong");
    a_ctrl_two_fields: assert property (REF_MULT == CTRL_TWO[7:3] &&
        VCO_RANGE == CTRL_TWO[2] && PUMP_CURRENT == CTRL_TWO[1:0]) else $error("field split");
    a_sweep_map_bit: assert property (SWEEP_MAP == CTRL_ONE[21])
        else $error("sweep map flag wrong");
    a_reset_clears: assert property ($fell(RST) |-> CTRL_ONE == 0 && CTRL_TWO == 0
        && !SEG_VALID) else $error("registers not cleared by reset");
    a_idle_regs_hold: assert property (CS_N && $past(CS_N) |->
        $stable(CTRL_ONE) && $stable(CTRL_TWO)) else $error("register changed while idle");
    a_profile_zero_empty: assert property ($past(!RST) && $past(sel == 2'b00) |->
        {SEG_MODE, SEG_NO_DWELL, SEG_BEGIN, SEG_FINAL, SEG_RATE} == 0 && !SEG_VALID)
        else $error("profile zero drives a segment");
    a_seg_fields_hold: assert property (s_quiet |->
        $stable({SEG_MODE, SEG_NO_DWELL, SEG_BEGIN, SEG_FINAL, SEG_RATE}))
        else $error("segment fields moved while idle");
endmodule // srp_checker
bind srp_profile_regs srp_checker #(.RAM_AW(RAM_AW)) srp_checker_inst (.CLK(CLK), .RST(RST),
    .CS_N(CS_N), .SDIO_OE_N(SDIO_OE_N), .PROFILE_SELECT_LOW(PROFILE_SELECT_LOW),
    .PROFILE_SELECT_HIGH(PROFILE_SELECT_HIGH), .CTRL_ONE(CTRL_ONE), .CTRL_TWO(CTRL_TWO),
    .REF_MULT(REF_MULT), .VCO_RANGE(VCO_RANGE), .PUMP_CURRENT(PUMP_CURRENT),
    .SWEEP_MAP(SWEEP_MAP), .SEG_VALID(SEG_VALID), .SEG_MODE(SEG_MODE),
    .SEG_NO_DWELL(SEG_NO_DWELL), .SEG_BEGIN(SEG_BEGIN), .SEG_FINAL(SEG_FINAL),
    .SEG_RATE(SEG_RATE));
`default_nettype wire

// file: tb/srp_host_model.sv
// Host side of the serial programming port
`timescale 1ns/1ps
`default_nettype none
module srp_host_model (
    input  wire logic CLK,
    input  wire logic SDIO_OUT,
    input  wire logic SDIO_OE_N,
    output var  logic CS_N,
    output var  logic SCLK,
    output var  logic SDIO_IN
);
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        SDIO_IN = 1'b0;
    end
    // Two low cycles per bit so read data has surely advanced before sampling
    task automatic shift(input logic b, output logic o, output logic e);
        @(posedge CLK);
        @(negedge CLK);
        o = SDIO_OUT;
        e = SDIO_OE_N;
        @(posedge CLK);
        SCLK <= 1'b1;
        SDIO_IN <= b;
        @(posedge CLK);
        SCLK <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] ins, input logic [39:0] d, input logic [5:0] n,
                         output logic [39:0] q, output logic ok);
        int i;
        logic o;
        logic e;
        q = 40'h0;
        ok = 1'b1;
        @(posedge CLK);
        CS_N <= 1'b0;
        for (i = 7; i >= 0; i--) shift(ins[i], o, e);
        for (i = n - 1; i >= 0; i--) begin
            shift(d[i], o, e);
            q[i] = o;
            if (ins[7] && e !== 1'b0) ok = 1'b0;
        end
        @(posedge CLK);
        CS_N <= 1'b1;
        // Released data line shows the inverse so a stale value cannot pass
        SDIO_IN <= ~SDIO_IN;
    endtask
endmodule // srp_host_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking testbench of the profile register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  sel = 2'b00;
    wire         cs_n, sclk, sdio_in, sdio_out, oe_n, vco, sweep, seg_valid, no_dwell;
    wire  [4:0]  ref_mult;
    wire  [1:0]  pump;
    wire  [2:0]  seg_mode;
    wire  [9:0]  seg_begin, seg_final, ram_addr;
    wire  [31:0] ram_data;
    wire  [15:0] seg_rate;
    int          num_errors = 0;
    int          compares = 0;
    int          i;
    logic [39:0] q;
    logic [31:0] sig = 32'h0;
    logic [39:0] seg [1:3] = '{40'h3C_A15E_F2B7, 40'h81_7E03_4D6A, 40'hFF_00AA_551C};
    always #5 clk = ~clk;
    srp_profile_regs srp_profile_regs_inst (.CLK(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk),
        .SDIO_IN(sdio_in), .SDIO_OUT(sdio_out), .SDIO_OE_N(oe_n), .PROFILE_SELECT_LOW(sel[0]),
        .PROFILE_SELECT_HIGH(sel[1]), .CTRL_ONE(), .CTRL_TWO(), .REF_MULT(ref_mult),
        .VCO_RANGE(vco), .PUMP_CURRENT(pump), .SWEEP_MAP(sweep), .SEG_VALID(seg_valid),
        .SEG_MODE(seg_mode), .SEG_NO_DWELL(no_dwell), .SEG_BEGIN(seg_begin),
        .SEG_FINAL(seg_final), .SEG_RATE(seg_rate), .RAM_ADDR(ram_addr),
        .RAM_DATA(ram_data));
    srp_host_model srp_host_model_inst (.CLK(clk), .SDIO_OUT(sdio_out), .SDIO_OE_N(oe_n),
        .CS_N(cs_n), .SCLK(sclk), .SDIO_IN(sdio_in));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [5:0] n, input logic [39:0] d);
        logic ok;
        srp_host_model_inst.frame({3'b000, a}, d, n, q, ok);
    endtask
    task automatic rd(input logic [4:0] a, input logic [5:0] n, input logic [39:0] e);
        logic ok;
        srp_host_model_inst.frame({3'b100, a}, 40'h0, n, q, ok);
        check(40'(ok), 40'h1);
        check(q, e);
    endtask
    task automatic pick(input logic [1:0] s);
        @(posedge clk);
        sel <= s;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    // Expected output fields of a segment word, in output port order
    function automatic logic [39:0] fields(input logic [39:0] w);
        fields = {w[7:5], w[4], w[3:0], w[15:10], w[9:8], w[23:16], w[31:24], w[39:32]};
    endfunction
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(5'h00, 32, 40'h0);
        rd(5'h01, 16, 40'h0);
        wr(5'h01, 16, 40'h1234);
        rd(5'h01, 16, 40'h1234);
        check(40'({ref_mult, vco, pump}), 40'h34);
        rd(5'h02, 1, 40'h0);
        for (i = 1; i <= 3; i++) wr(5'h07 + i[4:0], 40, seg[i]);
        for (i = 1; i <= 3; i++) begin
            pick(i[1:0]);
            check(40'(seg_valid), 40'h1);
            check({seg_mode, no_dwell, seg_begin, seg_final, seg_rate}, fields(seg[i]));
            rd(5'h07 + i[4:0], 40, seg[i]);
        end
        pick(2'd0);
        check({seg_mode, no_dwell, seg_begin, seg_final, seg_rate}, 40'h0);
        check(40'(seg_valid), 40'h0);
        wr(5'h00, 32, 40'h8000_0000);
        pick(2'd2);
        check({seg_mode, no_dwell, seg_begin, seg_final, seg_rate}, fields(seg[2]));
        rd(5'h09, 40, seg[2]);
        wr(5'h0B, 32, 40'hDEAD_BEEF);
        sig = {sig[30:0], sig[31]} ^ 32'hDEAD_BEEF;
        wr(5'h0B, 32, 40'h1357_9BDF);
        sig = {sig[30:0], sig[31]} ^ 32'h1357_9BDF;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(40'(ram_addr), 40'({seg[2][3:0], seg[2][15:10]}));
        check(40'(ram_data), 40'h1357_9BDF);
        rd(5'h0B, 32, 40'(sig));
        wr(5'h00, 32, 40'h0);
        wr(5'h0B, 32, 40'h0F0F_0F0F);
        rd(5'h0B, 32, 40'(sig));
        @(negedge clk);
        check(40'(ram_data), 40'h1357_9BDF);
        wr(5'h00, 32, 40'h0020_0000);
        pick(2'd3);
        check(40'({sweep, seg_valid}), 40'h2);
        rd(5'h0A, 1, 40'h0);
        wr(5'h0A, 40, 40'h0);
        wr(5'h00, 32, 40'h0);
        pick(2'd3);
        check({seg_mode, no_dwell, seg_begin, seg_final, seg_rate}, fields(seg[3]));
        rd(5'h0A, 40, seg[3]);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
